// file: common/csu_pkg.sv
// Package for the clock source unit: field resets, encodings, modes.
// Assumes a single system clock; no register bus, all controls are ports.
`default_nettype none
package csu_pkg;

    localparam logic [1:0] CSU_SRC_LOOP = 2'h0;
    localparam logic [1:0] CSU_SRC_INT = 2'h1;
    localparam logic [1:0] CSU_SRC_EXT = 2'h2;
    localparam logic [1:0] CSU_BUS_DIV_RESET = 2'h1;
    localparam logic [2:0] CSU_REF_DIV_RESET = 3'h0;
    localparam logic [8:0] CSU_TRIM_RESET = 9'h100;
    localparam int CSU_DBG_DIV = 2;

    typedef enum logic [2:0] {
        CSU_LOOP_ENGAGED_INTERNAL,
        CSU_LOOP_ENGAGED_EXTERNAL,
        CSU_LOOP_BYPASSED_INTERNAL,
        CSU_LOOP_BYPASSED_INTERNAL_LOWPOWER,
        CSU_LOOP_BYPASSED_EXTERNAL,
        CSU_LOOP_BYPASSED_EXTERNAL_LOWPOWER,
        CSU_STOP
    } csu_mode_t;

    // Controls for the low-power external oscillator
    typedef struct packed {
        logic oscillator_high_gain;
        logic range_high;
        logic external_ref_oscillator_select;
        logic external_ref_clock_enable;
        logic external_ref_stop_enable;
    } csu_osc_ctl_t;

endpackage
`default_nettype wire

// file: logic/csu_clock_source_unit.sv
// Clock source unit: mode control, reference and bus dividers, debug clock.
// Assumes the oscillator and reference clocks are sampled as pulses on
// clk_sys; every input from another domain is double synchronised here.
// Functional notes
// - Loop reference is internal or external, chosen by configuration.
// - System clock comes from loop, internal reference or external one.
// - Selected source passes bus divider; output runs at half divided rate.
// - Two-bit bus divider offers ratios one, two, four and eight.
// - Three-bit field sets divider on the loop reference clock.
// - Internal reference oscillator takes a nine-bit trim value.
// - Debug clock is loop oscillator divided by two.
// - Drive gain, range, select, enable and stop-enable to oscillator.
// - Reset leaves block in loop-engaged internal mode.
// - Engaged internal: loop on internal reference feeds system and debug.
// - Engaged external: loop on external reference feeds system and debug.
// - Bypassed internal: loop stays on; system from internal reference.
// - Bypassed internal low power: loop off, no debug clock.
// - Bypassed external: loop stays on; system from external reference.
// - Bypassed external low power: loop off, no debug clock.
// - Stop: loop off, references per configuration, no clocks out.
// - External reference may be oscillator or any other clock.
// - No port of this block reaches a package pin.
// - Reference divider is two to the field; resets to zero.
// - Bus divider codes one, two, four, eight; resets to code one.
// - Internal reference runs in stop only if stop-enabled, and then if enabled or internal mode before.
// - Low-power bit stops loop in bypass unless debug is active.
`timescale 1ns/1ps
`default_nettype none
module csu_clock_source_unit
    import csu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [1:0] clock_source_select,
    input wire logic [2:0] reference_divider,
    input wire logic loop_reference_select,
    input wire logic internal_ref_clock_enable,
    input wire logic internal_ref_stop_enable,
    input wire logic [1:0] bus_clock_divider,
    input wire logic bypass_low_power,
    input wire logic [8:0] internal_trim,
    input wire csu_osc_ctl_t osc_ctl_in,
    input wire logic background_debug_active,
    input wire logic stop_request,
    input wire logic loop_controlled_oscillator,
    input wire logic internal_ref_clock,
    input wire logic external_ref_clock,
    output logic system_clock_out,
    output logic debug_controller_clock,
    output logic loop_reference_clock,
    output logic loop_enable,
    output logic internal_ref_run,
    output logic [8:0] internal_trim_out,
    output csu_osc_ctl_t osc_ctl_out,
    output csu_mode_t mode_out
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Synchronisers: first stage read only by the second
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] sync_prev_reg;
    logic osc_s, irc_s, erc_s, osc_rise, irc_rise, erc_rise;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync_prev_reg <= 3'h0;
        end else begin
            sync1_reg <= {loop_controlled_oscillator, internal_ref_clock,
                          external_ref_clock};
            sync2_reg <= sync1_reg;
            sync_prev_reg <= sync2_reg;
        end
    end

    assign osc_s = sync2_reg[2];
    assign irc_s = sync2_reg[1];
    assign erc_s = sync2_reg[0];
    assign osc_rise = osc_s & ~sync_prev_reg[2];
    assign irc_rise = irc_s & ~sync_prev_reg[1];
    assign erc_rise = erc_s & ~sync_prev_reg[0];

    // Mode decode
    logic dbg_s1_reg, dbg_s2_reg, stop_s1_reg, stop_s2_reg;
    csu_mode_t mode_reg, mode_next, run_mode_reg, run_mode_next;
    logic low_pwr;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dbg_s1_reg <= 1'b0;
            dbg_s2_reg <= 1'b0;
            stop_s1_reg <= 1'b0;
            stop_s2_reg <= 1'b0;
        end else begin
            dbg_s1_reg <= background_debug_active;
            dbg_s2_reg <= dbg_s1_reg;
            stop_s1_reg <= stop_request;
            stop_s2_reg <= stop_s1_reg;
        end
    end

    // Debug needs its clock, so it overrides low power
    assign low_pwr = bypass_low_power & ~dbg_s2_reg;

    always_comb begin
        case (clock_source_select)
            CSU_SRC_INT:
                run_mode_next = low_pwr ? CSU_LOOP_BYPASSED_INTERNAL_LOWPOWER
                                        : CSU_LOOP_BYPASSED_INTERNAL;
            CSU_SRC_EXT:
                run_mode_next = low_pwr ? CSU_LOOP_BYPASSED_EXTERNAL_LOWPOWER
                                        : CSU_LOOP_BYPASSED_EXTERNAL;
            default:
                // Reserved code behaves as loop select
                run_mode_next = loop_reference_select
                    ? CSU_LOOP_ENGAGED_INTERNAL
                    : CSU_LOOP_ENGAGED_EXTERNAL;
        endcase
        // Remember the last running mode across stop
        if (stop_s2_reg) begin
            mode_next = CSU_STOP;
            run_mode_next = run_mode_reg;
        end else begin
            mode_next = run_mode_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= CSU_LOOP_ENGAGED_INTERNAL;
            run_mode_reg <= CSU_LOOP_ENGAGED_INTERNAL;
        end else begin
            mode_reg <= mode_next;
            run_mode_reg <= run_mode_next;
        end
    end

    // Enables per mode
    logic loop_on, irc_in_stop, sys_on, was_internal;
    assign was_internal = run_mode_reg == CSU_LOOP_ENGAGED_INTERNAL ||
        run_mode_reg == CSU_LOOP_BYPASSED_INTERNAL ||
        run_mode_reg == CSU_LOOP_BYPASSED_INTERNAL_LOWPOWER;
    assign irc_in_stop = internal_ref_stop_enable &
        (internal_ref_clock_enable | was_internal);

    always_comb begin
        case (mode_reg)
            CSU_LOOP_BYPASSED_INTERNAL_LOWPOWER,
            CSU_LOOP_BYPASSED_EXTERNAL_LOWPOWER: begin
                loop_on = 1'b0;
                sys_on = 1'b1;
            end
            CSU_STOP: begin
                loop_on = 1'b0;
                sys_on = 1'b0;
            end
            default: begin
                loop_on = 1'b1;
                sys_on = 1'b1;
            end
        endcase
    end

    // Reference divider feeding the loop, 2**field
    logic [7:0] refdiv_cnt_reg, refdiv_cnt_next;
    logic [7:0] refdiv_limit;
    logic ref_tick, lref_reg, lref_next;
    assign ref_tick = loop_reference_select ? irc_rise : erc_rise;
    assign refdiv_limit = 8'((9'h1 << reference_divider) - 9'h1);

    always_comb begin
        refdiv_cnt_next = refdiv_cnt_reg;
        lref_next = lref_reg;
        if (!loop_on) begin
            refdiv_cnt_next = 8'h0;
            lref_next = 1'b0;
        end else if (ref_tick) begin
            if (refdiv_cnt_reg >= refdiv_limit) begin
                refdiv_cnt_next = 8'h0;
                lref_next = ~lref_reg;
            end else begin
                refdiv_cnt_next = refdiv_cnt_reg + 8'h1;
            end
        end
    end

    // Source select and bus divider, toggling gives half-rate output
    logic src_tick;
    logic [2:0] busdiv_cnt_reg, busdiv_cnt_next;
    logic [2:0] busdiv_limit;
    logic sys_reg, sys_next, dbg_reg, dbg_next;

    always_comb begin
        case (mode_reg)
            CSU_LOOP_BYPASSED_INTERNAL,
            CSU_LOOP_BYPASSED_INTERNAL_LOWPOWER: src_tick = irc_rise;
            CSU_LOOP_BYPASSED_EXTERNAL,
            CSU_LOOP_BYPASSED_EXTERNAL_LOWPOWER: src_tick = erc_rise;
            default: src_tick = osc_rise;
        endcase
    end

    assign busdiv_limit = 3'((4'h1 << bus_clock_divider) - 4'h1);

    always_comb begin
        busdiv_cnt_next = busdiv_cnt_reg;
        sys_next = sys_reg;
        if (!sys_on) begin
            busdiv_cnt_next = 3'h0;
            sys_next = 1'b0;
        end else if (src_tick) begin
            if (busdiv_cnt_reg >= busdiv_limit) begin
                busdiv_cnt_next = 3'h0;
                sys_next = ~sys_reg;
            end else begin
                busdiv_cnt_next = busdiv_cnt_reg + 3'h1;
            end
        end
        // Debug clock needs the loop running
        dbg_next = loop_on ? (osc_rise ? ~dbg_reg : dbg_reg) : 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            refdiv_cnt_reg <= 8'h0;
            lref_reg <= 1'b0;
            busdiv_cnt_reg <= 3'h0;
            sys_reg <= 1'b0;
            dbg_reg <= 1'b0;
        end else begin
            refdiv_cnt_reg <= refdiv_cnt_next;
            lref_reg <= lref_next;
            busdiv_cnt_reg <= busdiv_cnt_next;
            sys_reg <= sys_next;
            dbg_reg <= dbg_next;
        end
    end

    // Static controls registered so outputs come from flops; none leave chip
    logic loop_en_reg, irc_run_reg;
    logic [8:0] trim_reg;
    csu_osc_ctl_t osc_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            loop_en_reg <= 1'b1;
            irc_run_reg <= 1'b1;
            trim_reg <= CSU_TRIM_RESET;
            osc_reg <= '0;
        end else begin
            loop_en_reg <= loop_on;
            irc_run_reg <= (mode_reg == CSU_STOP) ? irc_in_stop
                : (internal_ref_clock_enable | loop_reference_select |
                   was_internal);
            trim_reg <= internal_trim;
            osc_reg <= osc_ctl_in;
        end
    end

    assign system_clock_out = sys_reg;
    assign debug_controller_clock = dbg_reg;
    assign loop_reference_clock = lref_reg;
    assign loop_enable = loop_en_reg;
    assign internal_ref_run = irc_run_reg;
    assign internal_trim_out = trim_reg;
    assign osc_ctl_out = osc_reg;
    assign mode_out = mode_reg;

    // Checks
    sequence stop_seen_s;
        stop_s2_reg;
    endsequence
    sequence stop_quiet_s;
        mode_out == CSU_STOP ##1 !system_clock_out;
    endsequence
    sequence ext_bypass_s;
        mode_out == CSU_LOOP_BYPASSED_EXTERNAL ##1 loop_enable;
    endsequence

    stop_no_clock_a: assert property (stop_seen_s |=> stop_quiet_s)
        else $error("system clock active in stop");
    lowpower_loop_off_a: assert property (
        mode_reg == CSU_LOOP_BYPASSED_INTERNAL_LOWPOWER |=> !loop_enable)
        else $error("loop enabled in internal low power");
    lowpower_dbg_off_a: assert property (
        mode_reg == CSU_LOOP_BYPASSED_EXTERNAL_LOWPOWER
        |=> !debug_controller_clock)
        else $error("debug clock in external low power");
    debug_keeps_loop_a: assert property (
        dbg_s2_reg && !stop_s2_reg && clock_source_select == CSU_SRC_INT
        |=> mode_out == CSU_LOOP_BYPASSED_INTERNAL)
        else $error("debug did not keep loop on");
    mode_engaged_a: assert property (
        !stop_s2_reg && clock_source_select == CSU_SRC_LOOP &&
        loop_reference_select |=> mode_out == CSU_LOOP_ENGAGED_INTERNAL)
        else $error("wrong engaged mode");
    bypass_ext_a: assert property (
        !stop_s2_reg && clock_source_select == CSU_SRC_EXT && !low_pwr
        |=> ext_bypass_s)
        else $error("bypass external mode wrong");
    irc_stop_a: assert property (
        mode_reg == CSU_STOP && !internal_ref_stop_enable
        |=> !internal_ref_run)
        else $error("internal reference runs in stop");
    bus_div_a: assert property (
        sys_on && src_tick && busdiv_cnt_reg < busdiv_limit
        |=> $stable(system_clock_out))
        else $error("bus divider toggled early");
    dbg_half_a: assert property (
        loop_on && osc_rise
        |=> debug_controller_clock != $past(debug_controller_clock))
        else $error("debug clock missed loop edge");
endmodule
`default_nettype wire

// file: tb/csu_clk_partner.sv
// Far side model: loop oscillator, internal and external reference clocks.
// Assumes clk_sys runs much faster; sources are slow and phase unrelated.
`timescale 1ns/1ps
`default_nettype none
module csu_clk_partner (
    input wire logic loop_enable,
    input wire logic internal_ref_run,
    output logic loop_controlled_oscillator,
    output logic internal_ref_clock,
    output logic external_ref_clock
);
    initial begin
        loop_controlled_oscillator = 1'b0;
        internal_ref_clock = 1'b0;
        external_ref_clock = 1'b0;
    end
    // A disabled oscillator parks low instead of running on
    always #100 begin
        if (loop_enable === 1'b1) begin
            loop_controlled_oscillator = ~loop_controlled_oscillator;
        end else begin
            loop_controlled_oscillator = 1'b0;
        end
    end
    always #200 begin
        if (internal_ref_run === 1'b1) begin
            internal_ref_clock = ~internal_ref_clock;
        end else begin
            internal_ref_clock = 1'b0;
        end
    end
    // Plain external clock, not an oscillator: free running
    always #150 external_ref_clock = ~external_ref_clock;
endmodule
`default_nettype wire

// file: tb/csu_clock_source_unit_test.sv
// Testbench for the clock source unit: modes, dividers, stop, passthrough.
// Assumes the partner model supplies the three source clocks.
`timescale 1ns/1ps
`default_nettype none
module csu_clock_source_unit_test;
    import csu_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0;
    logic [1:0] clock_source_select = 2'h0;
    logic [1:0] bus_clock_divider = CSU_BUS_DIV_RESET;
    logic [2:0] reference_divider = CSU_REF_DIV_RESET;
    logic loop_reference_select = 1'b1, internal_ref_clock_enable = 1'b0;
    logic internal_ref_stop_enable = 1'b0, bypass_low_power = 1'b0;
    logic background_debug_active = 1'b0, stop_request = 1'b0;
    logic [8:0] internal_trim = 9'h000;
    csu_osc_ctl_t osc_ctl_in = 5'h00;
    logic loop_controlled_oscillator, internal_ref_clock, external_ref_clock;
    logic system_clock_out, debug_controller_clock, loop_reference_clock;
    logic loop_enable, internal_ref_run;
    logic [8:0] internal_trim_out;
    csu_osc_ctl_t osc_ctl_out;
    csu_mode_t mode_out;
    int n_mismatch = 0, total_checks = 0, cyc = 0, src, n_osc, n_ir, n_er;
    int n_sys, n_dbg, n_ref;
    bit meas = 1'b0;
    logic le;
    // Control table: {source, reference select, low power, debug}
    logic [4:0] t_ctl [8] = '{5'h04, 5'h00, 5'h0c, 5'h0e,
        5'h10, 5'h12, 5'h1c, 5'h0f};
    csu_mode_t t_mode [8] = '{CSU_LOOP_ENGAGED_INTERNAL,
        CSU_LOOP_ENGAGED_EXTERNAL, CSU_LOOP_BYPASSED_INTERNAL,
        CSU_LOOP_BYPASSED_INTERNAL_LOWPOWER, CSU_LOOP_BYPASSED_EXTERNAL,
        CSU_LOOP_BYPASSED_EXTERNAL_LOWPOWER, CSU_LOOP_ENGAGED_INTERNAL,
        CSU_LOOP_BYPASSED_INTERNAL};

    always #12.5 clk_sys = ~clk_sys;

    csu_clock_source_unit i_dut (.clk_sys, .rst_n, .clock_source_select,
        .reference_divider, .loop_reference_select, .internal_ref_clock_enable,
        .internal_ref_stop_enable, .bus_clock_divider, .bypass_low_power,
        .internal_trim, .osc_ctl_in, .background_debug_active, .stop_request,
        .loop_controlled_oscillator, .internal_ref_clock, .external_ref_clock,
        .system_clock_out, .debug_controller_clock, .loop_reference_clock,
        .loop_enable, .internal_ref_run, .internal_trim_out, .osc_ctl_out,
        .mode_out);

    csu_clk_partner i_far (.loop_enable, .internal_ref_run,
        .loop_controlled_oscillator, .internal_ref_clock, .external_ref_clock);

    always @(posedge loop_controlled_oscillator) if (meas) n_osc++;
    always @(posedge internal_ref_clock) if (meas) n_ir++;
    always @(posedge external_ref_clock) if (meas) n_er++;
    always @(system_clock_out) if (meas) n_sys++;
    always @(debug_controller_clock) if (meas) n_dbg++;
    always @(loop_reference_clock) if (meas) n_ref++;

    task automatic results();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic fail(logic [8:0] got, logic [8:0] exp);
        n_mismatch++;
        $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    endtask

    task automatic chk_vec(logic [8:0] got, logic [8:0] exp);
        total_checks++;
        if (got !== exp) fail(got, exp);
    endtask

    task automatic chk_mode(csu_mode_t got, csu_mode_t exp);
        total_checks++;
        if (got !== exp) fail({6'h00, got}, {6'h00, exp});
    endtask

    // Sync stages and window edges blur a count by a couple of toggles
    task automatic chk_count(int got, int exp);
        total_checks++;
        if (got > exp + 2 || got + 2 < exp) fail(got[8:0], exp[8:0]);
    endtask

    task automatic step(int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask

    task automatic measure();
        {n_osc, n_ir, n_er, n_sys, n_dbg, n_ref} = '0;
        meas = 1'b1;
        step(800);
        meas = 1'b0;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        step(8);
        chk_mode(mode_out, CSU_LOOP_ENGAGED_INTERNAL);
        chk_vec(internal_trim_out, CSU_TRIM_RESET);
        chk_vec({4'h0, osc_ctl_out}, 9'h000);
        rst_n = 1'b1;
        step(10);
        chk_mode(mode_out, CSU_LOOP_ENGAGED_INTERNAL);
        for (int i = 0; i < 8; i++) begin
            {clock_source_select, loop_reference_select, bypass_low_power,
                background_debug_active} = t_ctl[i];
            bus_clock_divider = 2'(i);
            reference_divider = 3'(i);
            step(10);
            chk_mode(mode_out, t_mode[i]);
            le = !(t_ctl[i][4:3] inside {2'h1, 2'h2} && t_ctl[i][1] &&
                !t_ctl[i][0]);
            chk_vec({8'h00, loop_enable}, {8'h00, le});
            measure();
            src = t_ctl[i][4:3] == 2'h1 ? n_ir :
                t_ctl[i][4:3] == 2'h2 ? n_er : n_osc;
            chk_count(n_sys, src >> (i % 4));
            chk_count(n_dbg, le ? n_osc : 0);
            src = t_ctl[i][2] ? n_ir : n_er;
            if (le) chk_count(n_ref, src >> i);
        end
        {clock_source_select, loop_reference_select, bypass_low_power,
            background_debug_active} = 5'h0c;
        internal_ref_stop_enable = 1'b1;
        step(10);
        stop_request = 1'b1;
        step(10);
        chk_mode(mode_out, CSU_STOP);
        chk_vec({8'h00, loop_enable}, 9'h000);
        chk_vec({8'h00, internal_ref_run}, 9'h001);
        measure();
        chk_count(n_sys, 0);
        chk_count(n_dbg, 0);
        stop_request = 1'b0;
        {clock_source_select, loop_reference_select} = 3'h0;
        step(10);
        stop_request = 1'b1;
        step(10);
        chk_vec({8'h00, internal_ref_run}, 9'h000);
        internal_ref_clock_enable = 1'b1;
        step(4);
        chk_vec({8'h00, internal_ref_run}, 9'h001);
        internal_ref_stop_enable = 1'b0;
        step(4);
        chk_vec({8'h00, internal_ref_run}, 9'h000);
        stop_request = 1'b0;
        for (int j = 0; j < 2; j++) begin
            internal_trim = j ? 9'h15a : 9'h0a5;
            osc_ctl_in = j ? 5'h0a : 5'h15;
            step(2);
            chk_vec(internal_trim_out, internal_trim);
            chk_vec({4'h0, osc_ctl_out}, {4'h0, osc_ctl_in});
        end
        results();
    end
endmodule
`default_nettype wire
